// ==== design/sfsp_device.sv ====
// Purpose: Flash end: status register, write latch, protection, power-down, small erase
// Assumes: SPI mode 0 or 3, link pins sampled by core_clk_i well above sck rate
// Notes: Array contents are not held; an erase is reported on erase_start_o
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module sfsp_device
  import sfsp_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 5000,
  parameter int unsigned WRSR_CYCLES = 5000
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  sfsp_link_if.flash link,
  output logic [7:0] status_o,
  output logic erase_start_o,
  output logic [5:0] erase_block_o,
  output logic power_down_o
);

  logic [3:0] pins_raw;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic sck_prev_reg;
  logic cs_prev_reg;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic selected;
  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [7:0] byte_in;
  logic byte_done;
  logic rd_arm_reg;
  logic [2:0] out_idx_reg;
  logic so_reg;
  logic so_oe_reg;
  logic pl_lo_reg;
  logic pl_hi_reg;
  logic lock_reg;
  logic wel_reg;
  logic busy_reg;
  logic [23:0] busy_cnt_reg;
  logic pd_reg;
  logic [7:0] status_now;
  logic frame_ok;
  logic do_wren;
  logic do_wrdi;
  logic do_wrsr;
  logic do_sse;
  logic do_pdn;
  logic wake;
  logic erase_start_reg;
  logic [5:0] erase_block_reg;
  logic [7:0] status_reg;

  // True when the address falls inside the range the protect level covers
  function automatic logic is_protected(input logic [1:0] level, input logic [17:0] addr);
    logic hit;
    hit = 1'b1;
    unique case (level)
      PL_NONE: hit = 1'b0;
      PL_QUARTER: hit = (addr >= PROT_Q_BASE);
      PL_HALF: hit = (addr >= PROT_H_BASE);
      default: hit = (addr >= PROT_ALL_BASE);
    endcase
    return hit;
  endfunction

  // Two-flop synchroniser for every link pin
  assign pins_raw = {link.wp, link.si, link.sck, link.cs_n};

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_meta_reg <= 4'h1;
      pin_sync_reg <= 4'h1;
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= pins_raw;
      pin_sync_reg <= pin_meta_reg;
      sck_prev_reg <= pin_sync_reg[PIN_SCK];
      cs_prev_reg <= pin_sync_reg[PIN_CS];
    end
  end

  // Edge detection on the synchronised pins
  assign selected = !pin_sync_reg[PIN_CS];
  assign sck_rise = selected && pin_sync_reg[PIN_SCK] && !sck_prev_reg;
  assign sck_fall = selected && !pin_sync_reg[PIN_SCK] && sck_prev_reg;
  assign cs_rise = pin_sync_reg[PIN_CS] && !cs_prev_reg;
  assign byte_in = {shift_reg, pin_sync_reg[PIN_SI]};
  assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);

  // Shift input bits MSB first on rising sck; collect opcode and address
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shift_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
    end
    else if (!selected)
    begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end
    else if (sck_rise)
    begin
      shift_reg <= byte_in[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7)
      begin
        if (byte_cnt_reg == 3'h0)
          opcode_reg <= byte_in;
        else
          addr_reg <= {addr_reg[15:0], byte_in};
        if (byte_cnt_reg != LEN_MAX)
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  // Live status image
  always_comb
  begin
    status_now = 8'h00;
    status_now[ST_BUSY] = busy_reg;
    status_now[ST_WEL] = wel_reg;
    status_now[ST_PL_LO] = pl_lo_reg;
    status_now[ST_PL_HI] = pl_hi_reg;
    status_now[ST_LOCK] = lock_reg;
  end

  // Status read output, armed even while busy, silent in power-down
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_arm_reg <= 1'b0;
      out_idx_reg <= ST_FIRST;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end
    else if (!selected)
    begin
      rd_arm_reg <= 1'b0;
      out_idx_reg <= ST_FIRST;
      so_oe_reg <= 1'b0;
    end
    else
    begin
      if (byte_done && byte_cnt_reg == 3'h0 && byte_in == OP_RDSR && !pd_reg)
        rd_arm_reg <= 1'b1;
      if (sck_fall && rd_arm_reg)
      begin
        so_reg <= status_now[out_idx_reg];
        so_oe_reg <= 1'b1;
        out_idx_reg <= out_idx_reg - 3'h1;
      end
    end
  end

  assign link.so = so_reg;
  assign link.so_oe = so_oe_reg;

  // Command decode at the end of a whole-byte frame; wake at the end of the opcode byte
  assign frame_ok = cs_rise && (bit_cnt_reg == 3'h0) && !pd_reg;
  assign do_wren = frame_ok && opcode_reg == OP_WREN && byte_cnt_reg == LEN_ONE;
  assign do_wrdi = frame_ok && opcode_reg == OP_WRDI && byte_cnt_reg == LEN_ONE;
  assign do_wrsr = frame_ok && opcode_reg == OP_WRSR && byte_cnt_reg == LEN_WRSR
                   && wel_reg && !busy_reg
                   && !(lock_reg && !pin_sync_reg[PIN_WP]);
  assign do_sse = frame_ok && opcode_reg == OP_SSE && byte_cnt_reg == LEN_SSE
                  && wel_reg && !busy_reg
                  && !is_protected({pl_hi_reg, pl_lo_reg},
                                   {addr_reg[17:12], 12'h000});
  assign do_pdn = frame_ok && opcode_reg == OP_PDN && byte_cnt_reg == LEN_ONE
                  && !busy_reg;
  assign wake = byte_done && byte_cnt_reg == 3'h0 && byte_in == OP_PDX;

  // Nonvolatile protect and lock bits; other status bits are never written
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      {lock_reg, pl_hi_reg, pl_lo_reg} <= NV_RESET;
    else if (do_wrsr)
      {lock_reg, pl_hi_reg, pl_lo_reg} <=
        {addr_reg[ST_LOCK], addr_reg[ST_PL_HI], addr_reg[ST_PL_LO]};
  end

  // Internal write timer for status write and small erase
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= 24'h000000;
    end
    else if (do_wrsr)
    begin
      busy_reg <= 1'b1;
      busy_cnt_reg <= 24'(WRSR_CYCLES);
    end
    else if (do_sse)
    begin
      busy_reg <= 1'b1;
      busy_cnt_reg <= 24'(ERASE_CYCLES);
    end
    else if (busy_reg)
    begin
      busy_cnt_reg <= busy_cnt_reg - 24'h000001;
      if (busy_cnt_reg <= 24'h000001)
        busy_reg <= 1'b0;
    end
  end

  // Write latch: cleared at reset, by disable and on completion; enable wins
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wel_reg <= 1'b0;
    else if (do_wren)
      wel_reg <= 1'b1;
    else if (do_wrdi)
      wel_reg <= 1'b0;
    else if (busy_reg && busy_cnt_reg <= 24'h000001)
      wel_reg <= 1'b0;
  end

  // Power-down state
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pd_reg <= 1'b0;
    else if (wake && pd_reg)
      pd_reg <= 1'b0;
    else if (do_pdn)
      pd_reg <= 1'b1;
  end

  // Registered user-side outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      erase_start_reg <= 1'b0;
      erase_block_reg <= 6'h00;
      status_reg <= 8'h00;
    end
    else
    begin
      erase_start_reg <= do_sse;
      if (do_sse)
        erase_block_reg <= addr_reg[17:12];
      status_reg <= status_now;
    end
  end

  assign status_o = status_reg;
  assign erase_start_o = erase_start_reg;
  assign erase_block_o = erase_block_reg;
  assign power_down_o = pd_reg;

endmodule

// ==== design/sfsp_host.sv ====
// Purpose: Controller end: runs serial frames ordered over an Avalon-MM slave
// Assumes: SPI mode 0, serial clock divided from core_clk_i
// Notes: Registers CMD, TXDATA, RXDATA, STAT and CTRL; one-cycle waitrequest answer
`timescale 1ns/10ps
module sfsp_host
  import sfsp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  sfsp_link_if.ctrl link,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  typedef enum logic [2:0] {SFSP_IDLE, SFSP_LEAD, SFSP_LOW, SFSP_HIGH, SFSP_TRAIL,
                            SFSP_GAP} sfsp_hstate_t;

  sfsp_hstate_t state_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [13:0] cmd_reg;
  logic [31:0] txdata_reg;
  logic [31:0] rxdata_reg;
  logic wp_reg;
  logic [39:0] tx_sr_reg;
  logic [6:0] bits_left_reg;
  logic [4:0] div_cnt_reg;
  logic cs_n_reg;
  logic sck_reg;
  logic si_reg;
  logic so_meta_reg;
  logic so_sync_reg;
  logic half_done;
  logic take_wr;
  logic start;
  logic [2:0] tx_n;
  logic [2:0] rx_n;

  assign take_wr = avs_write_i && !wait_reg;
  assign start = take_wr && avs_address_i == REG_CMD && state_reg == SFSP_IDLE;
  assign tx_n = avs_writedata_i[CMD_TX_LSB +: 3];
  assign rx_n = avs_writedata_i[CMD_RX_LSB +: 3];
  assign half_done = div_cnt_reg == 5'(SCK_HALF_CYC - 1);

  // Waitrequest drops for one cycle per request; read data ready at that edge
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      wait_reg <= !((avs_read_i || avs_write_i) && wait_reg);
      if (avs_read_i && wait_reg)
      begin
        unique case (avs_address_i)
          REG_CMD: rdata_reg <= {18'h00000, cmd_reg};
          REG_TXDATA: rdata_reg <= txdata_reg;
          REG_RXDATA: rdata_reg <= rxdata_reg;
          REG_STAT: rdata_reg <= {30'h00000000, wp_reg, state_reg != SFSP_IDLE};
          REG_CTRL: rdata_reg <= {31'h00000000, wp_reg};
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // Software-written registers
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_reg <= 14'h0000;
      txdata_reg <= 32'h00000000;
      wp_reg <= 1'b0;
    end
    else if (take_wr)
    begin
      if (start)
        cmd_reg <= avs_writedata_i[13:0];
      if (avs_address_i == REG_TXDATA)
        txdata_reg <= avs_writedata_i;
      if (avs_address_i == REG_CTRL)
        wp_reg <= avs_writedata_i[0];
    end
  end

  // Serial output synchroniser
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      so_meta_reg <= 1'b1;
      so_sync_reg <= 1'b1;
    end
    else
    begin
      so_meta_reg <= link.so_line;
      so_sync_reg <= so_meta_reg;
    end
  end

  // Frame engine: opcode, then tx bytes, then rx bytes, MSB first
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= SFSP_IDLE;
      div_cnt_reg <= 5'h00;
      bits_left_reg <= 7'h00;
      tx_sr_reg <= 40'h0000000000;
      rxdata_reg <= 32'h00000000;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      si_reg <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= (state_reg == SFSP_IDLE || half_done) ? 5'h00 : div_cnt_reg + 5'h01;
      unique case (state_reg)
        SFSP_IDLE:
          if (start)
          begin
            tx_sr_reg <= {avs_writedata_i[7:0], txdata_reg};
            // Seven bits: eight whole bytes already need 64 clock rises
            bits_left_reg <= 7'(({4'h0, tx_n} + {4'h0, rx_n} + 7'h01) << 3);
            cs_n_reg <= 1'b0;
            state_reg <= SFSP_LEAD;
          end
        SFSP_LEAD:
          if (half_done)
          begin
            si_reg <= tx_sr_reg[39];
            tx_sr_reg <= {tx_sr_reg[38:0], 1'b0};
            state_reg <= SFSP_LOW;
          end
        SFSP_LOW:
          if (half_done)
          begin
            sck_reg <= 1'b1;
            rxdata_reg <= {rxdata_reg[30:0], so_sync_reg};
            bits_left_reg <= bits_left_reg - 7'h01;
            state_reg <= SFSP_HIGH;
          end
        SFSP_HIGH:
          if (half_done)
          begin
            sck_reg <= 1'b0;
            if (bits_left_reg == 7'h00)
              state_reg <= SFSP_TRAIL;
            else
            begin
              si_reg <= tx_sr_reg[39];
              tx_sr_reg <= {tx_sr_reg[38:0], 1'b0};
              state_reg <= SFSP_LOW;
            end
          end
        SFSP_TRAIL:
          if (half_done)
          begin
            cs_n_reg <= 1'b1;
            state_reg <= SFSP_GAP;
          end
        SFSP_GAP:
          if (half_done)
            state_reg <= SFSP_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sck = sck_reg;
  assign link.si = si_reg;
  assign link.wp = wp_reg;
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

endmodule

// ==== design/sfsp_link_if.sv ====
// Purpose: Serial link between the flash end and the controller end
// Assumes: Serial output idles high through a pull-up when undriven
// Notes: so_line is the resolved level of the serial output wire
`timescale 1ns/10ps
interface sfsp_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic wp;
  logic so;
  logic so_oe;
  logic so_line;

  // Resolve the shared output wire with a weak pull-up
  assign so_line = so_oe ? so : 1'b1;

  modport flash (input cs_n, input sck, input si, input wp, output so, output so_oe);
  modport ctrl (output cs_n, output sck, output si, output wp, input so_line);
endinterface

// ==== design/sfsp_pkg.sv ====
// Purpose: Shared constants for the serial flash status and protect link
// Assumes: Both ends and the bench import this package
// Notes: Opcodes, status bit positions, protect bounds and host register map
package sfsp_pkg;
  // Command opcodes
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_PDN = 8'hb9;
  localparam logic [7:0] OP_PDX = 8'hab;
  localparam logic [7:0] OP_SSE = 8'hd7;
  // Whole bytes each command must carry, opcode included; LEN_MAX caps the device byte count
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_WRSR = 3'h2;
  localparam logic [2:0] LEN_SSE = 3'h4;
  localparam logic [2:0] LEN_MAX = 3'h7;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_PL_LO = 2;
  localparam int ST_PL_HI = 3;
  localparam int ST_LOCK = 7;
  localparam logic [2:0] ST_FIRST = 3'h7;
  // Protect level codes and lowest protected address
  localparam logic [1:0] PL_NONE = 2'h0;
  localparam logic [1:0] PL_QUARTER = 2'h1;
  localparam logic [1:0] PL_HALF = 2'h2;
  localparam logic [17:0] PROT_Q_BASE = 18'h30000;
  localparam logic [17:0] PROT_H_BASE = 18'h20000;
  localparam logic [17:0] PROT_ALL_BASE = 18'h00000;
  localparam logic [2:0] NV_RESET = 3'h0;
  // Pin positions in the device synchroniser
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  // Host serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int SCK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // Host register byte offsets and command fields
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_TXDATA = 5'h04;
  localparam logic [4:0] REG_RXDATA = 5'h08;
  localparam logic [4:0] REG_STAT = 5'h0c;
  localparam logic [4:0] REG_CTRL = 5'h10;
  localparam int CMD_TX_LSB = 8;
  localparam int CMD_RX_LSB = 11;
endpackage

// ==== test/sfsp_chk.sv ====
// Purpose: Concurrent checks on the serial link between the two ends
// Assumes: Link signals sampled by the core clock, mode 0 framing
// Notes: Helper counters track clock rises per frame and cycles since a fall
`timescale 1ns/10ps
module sfsp_chk
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp,
  input wire logic so,
  input wire logic so_oe
);
  logic sck_reg;
  logic [6:0] rise_cnt_reg;
  logic [3:0] since_fall_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Serial clock one cycle late, for edge finding
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sck_reg <= 1'b0;
    else
      sck_reg <= sck;
  end

  // Clock rises within the current frame
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rise_cnt_reg <= 7'h00;
    else if (cs_n)
      rise_cnt_reg <= 7'h00;
    else if (sck && !sck_reg && rise_cnt_reg != 7'h7f)
      rise_cnt_reg <= rise_cnt_reg + 7'h01;
  end

  // Cycles since the last clock fall, saturating
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      since_fall_reg <= 4'hf;
    else if (sck_reg && !sck)
      since_fall_reg <= 4'h0;
    else if (since_fall_reg != 4'hf)
      since_fall_reg <= since_fall_reg + 4'h1;
  end

  sequence s_sck_high8;
    sck [*8];
  endsequence
  sequence s_drive_off;
    ##[0:5] !so_oe;
  endsequence

  property p_out_after_cmd;
    $rose(so_oe) |-> rise_cnt_reg >= 7'h08 && since_fall_reg <= 4'h6 && !cs_n;
  endproperty
  property p_bit_on_fall;
    so_oe && $past(so_oe) && $changed(so) |-> since_fall_reg <= 4'h6;
  endproperty
  property p_sck_half;
    $rose(sck) |-> s_sck_high8 ##1 !sck;
  endproperty
  property p_whole_bytes;
    $rose(cs_n) |-> rise_cnt_reg[2:0] == 3'h0 && !sck;
  endproperty
  property p_si_steady;
    sck && $past(sck) |-> $stable(si);
  endproperty
  property p_off_after_cs;
    $rose(cs_n) |-> s_drive_off;
  endproperty
  property p_idle_off;
    cs_n [*8] |-> !so_oe;
  endproperty
  property p_wp_steady;
    !cs_n && !$past(cs_n) |-> $stable(wp);
  endproperty

  a_out_after_cmd: assert property (p_out_after_cmd)
    else $error("serial output enabled outside a status reply");
  a_bit_on_fall: assert property (p_bit_on_fall)
    else $error("serial output changed away from a clock fall");
  a_sck_half: assert property (p_sck_half)
    else $error("serial clock high phase not eight cycles");
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("frame ended inside a byte");
  a_si_steady: assert property (p_si_steady)
    else $error("serial input moved while clock high");
  a_off_after_cs: assert property (p_off_after_cs)
    else $error("serial output still driven after deselect");
  a_idle_off: assert property (p_idle_off)
    else $error("serial output driven while deselected");
  a_wp_steady: assert property (p_wp_steady)
    else $error("protect pin moved inside a frame");
endmodule

// ==== test/testbench.sv ====
// Purpose: Self-checking bench joining the flash end and the controller end
// Assumes: Busy times shortened by parameter; the controller makes the link clock
// Notes: Frames are ordered over the controller's Avalon registers
`timescale 1ns/10ps
module testbench
  import sfsp_pkg::*;
;
  localparam int unsigned BUSY_CYC = 800;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] status;
  logic erase_start;
  logic [5:0] erase_block;
  logic power_down;
  int n_fail = 0;
  int checked = 0;
  int n_erase = 0;

  // Both ends and the link checker
  sfsp_link_if link();
  sfsp_device #(.ERASE_CYCLES(300), .WRSR_CYCLES(BUSY_CYC)) i_sfsp_device (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link(link), .status_o(status),
    .erase_start_o(erase_start), .erase_block_o(erase_block), .power_down_o(power_down));
  sfsp_host i_sfsp_host (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link(link),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest));
  sfsp_chk i_sfsp_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cs_n(link.cs_n),
    .sck(link.sck), .si(link.si), .wp(link.wp), .so(link.so), .so_oe(link.so_oe));

  // Clock and erase pulse counter
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
    if (erase_start === 1'b1)
      n_erase <= n_erase + 1;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk_i);
    // Only the watchdog ends a wait that never gets its answer
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk_i);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // One serial frame, then wait for the controller to go idle
  task automatic frame(input logic [7:0] op, input logic [2:0] ntx, input logic [2:0] nrx,
    input logic [31:0] tx);
    logic [31:0] st;
    int n;
    n = 0;
    bus(1'b1, REG_TXDATA, tx, st);
    bus(1'b1, REG_CMD, {18'h0, nrx, ntx, op}, st);
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 500)
    begin
      bus(1'b0, REG_STAT, 32'h0, st);
      n++;
    end
    chk("frame done", st[0], 1'b0);
  endtask

  task automatic rdsr(input logic [2:0] nrx, output logic [31:0] rx);
    frame(OP_RDSR, 3'h0, nrx, 32'h0);
    bus(1'b0, REG_RXDATA, 32'h0, rx);
  endtask

  task automatic wait_idle();
    logic [31:0] rx;
    int n;
    n = 0;
    rx = 32'h1;
    while (rx[ST_BUSY] !== 1'b0 && n < 30)
    begin
      rdsr(3'h1, rx);
      n++;
    end
    chk("busy clears", rx[ST_BUSY], 1'b0);
  endtask

  task automatic st_chk(input logic [7:0] e);
    logic [31:0] rx;
    rdsr(3'h1, rx);
    chk("status read", rx[7:0], e);
    chk("status port", status, e);
  endtask

  task automatic cmd1(input logic [7:0] op);
    frame(op, 3'h0, 3'h0, 32'h0);
  endtask

  // Status after a write: only lock and protect bits follow the data
  function automatic logic [7:0] wrsr_exp(input logic [7:0] d);
    return {d[7], 3'h0, d[3:2], 2'h0};
  endfunction

  // Whether the erase block holding an address is protected at a level
  function automatic logic is_prot(input logic [1:0] pl, input logic [23:0] a);
    logic [17:0] base;
    base = {a[17:12], 12'h000};
    case (pl)
      PL_NONE: return 1'b0;
      PL_QUARTER: return base >= PROT_Q_BASE;
      PL_HALF: return base >= PROT_H_BASE;
      default: return 1'b1;
    endcase
  endfunction

  // Watchdog against a hung run
  initial
  begin
    #800000;
    n_fail++;
    $display("[FAIL] watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial
  begin
    logic [31:0] rx;
    logic [31:0] r;
    logic [7:0] e;
    logic [23:0] a;
    logic [1:0] pl;
    int e0;
    r = $urandom(68);
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    // Reset state, unmapped register, latch commands, refused write
    st_chk(8'h00);
    bus(1'b0, 5'h14, 32'h0, rx);
    chk("unmapped read", rx, 32'h0);
    cmd1(OP_WREN);
    st_chk(8'h02);
    cmd1(OP_WRDI);
    st_chk(8'h00);
    bus(1'b1, REG_CTRL, 32'h1, rx);
    bus(1'b0, REG_STAT, 32'h0, rx);
    chk("protect pin", rx[1], 1'b1);
    frame(OP_WRSR, 3'h1, 3'h0, 32'hff00_0000);
    st_chk(8'h00);
    // Random status write, read twice while busy, power-down refused
    e = wrsr_exp(r[7:0]);
    cmd1(OP_WREN);
    frame(OP_WRSR, 3'h1, 3'h0, {r[7:0], 24'h0});
    rdsr(3'h2, rx);
    chk("busy status twice", rx[15:0], {2{e | 8'h03}});
    cmd1(OP_PDN);
    chk("power down while busy", power_down, 1'b0);
    wait_idle();
    st_chk(e);
    // Lock bit against the protect pin
    cmd1(OP_WREN);
    frame(OP_WRSR, 3'h1, 3'h0, 32'h8000_0000);
    wait_idle();
    bus(1'b1, REG_CTRL, 32'h0, rx);
    cmd1(OP_WREN);
    frame(OP_WRSR, 3'h1, 3'h0, 32'h0c00_0000);
    st_chk(8'h82);
    bus(1'b1, REG_CTRL, 32'h1, rx);
    frame(OP_WRSR, 3'h1, 3'h0, 32'h0);
    wait_idle();
    st_chk(8'h00);
    // Every protect level against boundary and random erase blocks
    for (int k = 0; k < 4; k++)
    begin
      pl = k[1:0];
      cmd1(OP_WREN);
      frame(OP_WRSR, 3'h1, 3'h0, {4'h0, pl, 26'h0});
      wait_idle();
      for (int j = 0; j < 3; j++)
      begin
        a = (j == 0) ? 24'hfef000 : (j == 1) ? 24'h030000 : 24'($urandom);
        cmd1(OP_WREN);
        e0 = n_erase;
        frame(OP_SSE, 3'h3, 3'h0, {a, 8'h00});
        wait_idle();
        chk("erase count", 32'(n_erase - e0), is_prot(pl, a) ? 32'h0 : 32'h1);
        chk("latch after erase", status[ST_WEL], is_prot(pl, a));
        if (!is_prot(pl, a))
          chk("erase block", erase_block, a[17:12]);
      end
    end
    // Erase refused with latch clear and with a short frame, level 1 kept
    cmd1(OP_WREN);
    frame(OP_WRSR, 3'h1, 3'h0, 32'h0400_0000);
    wait_idle();
    e0 = n_erase;
    frame(OP_SSE, 3'h3, 3'h0, 32'h0);
    cmd1(OP_WREN);
    frame(OP_SSE, 3'h2, 3'h0, 32'h0);
    chk("refused erases", 32'(n_erase - e0), 32'h0);
    st_chk(8'h06);
    // Power-down entry, refused commands, both ways out
    cmd1(OP_PDN);
    chk("power down", power_down, 1'b1);
    cmd1(OP_WRDI);
    rdsr(3'h1, rx);
    chk("output off in power down", rx[7:0], 8'hff);
    cmd1(OP_PDX);
    chk("power up", power_down, 1'b0);
    st_chk(8'h06);
    cmd1(OP_PDN);
    frame(OP_PDX, 3'h3, 3'h0, $urandom);
    chk("power up by id read", power_down, 1'b0);
    st_chk(8'h06);
    tally_and_finish();
  end
endmodule
